/* File: shared/gpied_pkg.sv */
// Purpose: shared constants and types for the gpio input edge detect block
// Assumes: register port driven by the serial host interface logic
// Notes:   offsets are register indices on the internal register port
`default_nettype none
package gpied_pkg;
  localparam int unsigned NPINS = 6;
  localparam int unsigned AW    = 8;
  localparam int unsigned DW    = 24;

  // register indices
  localparam logic [7:0] OFS_PORT_CTRL   = 8'h04;
  localparam logic [7:0] OFS_EDGE_ENABLE = 8'h05;
  localparam logic [7:0] OFS_INPUT_DATA  = 8'h06;
  localparam logic [7:0] OFS_INT_SUMMARY = 8'h07;

  // field positions (low bit of each six-bit field)
  localparam int unsigned POS_HI  = 16;
  localparam int unsigned POS_MID = 8;
  localparam int unsigned POS_LO  = 0;

  // values after reset
  localparam logic [5:0]  RST_FIELD = 6'h00;
  localparam logic [23:0] RST_WORD  = 24'h000000;

  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [23:0] wdata;
  } gpied_req_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } gpied_rsp_t;
endpackage
`default_nettype wire

/* File: hw/gpied_sync.sv */
// Purpose: two-flop synchroniser for the input pins
// Assumes: pins are asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
`default_nettype none
module gpied_sync #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } gpied_sync_state_t;

  gpied_sync_state_t s;
  gpied_sync_state_t next_s;

  always_comb
  begin
    next_s        = s;
    next_s.meta   = pin_async;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pin_sync = s.stable;
endmodule
`default_nettype wire

/* File: hw/gpied_top.sv */
// Purpose: input side of a six-pin gpio port: levels, edge detection, sticky flags
// Assumes: register requests arrive from the serial host interface, one cycle each
// Notes:   read data appears one cycle after the read request, with rsp.valid
//
// Function
// - falling edges on a pin are flagged only if its fall enable bit is set
// - rising edge on an input pin sets its sticky rise flag, bits 21:16
// - falling edge on an input pin sets its sticky fall flag, bits 13:8
// - reading the status register returns flags then clears them; concurrent edges survive
// - status bits 5:0 show present level of each enabled input pin, zero for other pins, read only
// - after reset all rise and fall flags are zero
// - rising edges on a pin are flagged only if its rise enable bit is set
// - pins with direction bit zero are inputs; only inputs are sampled and detected
// - pins whose enable bit is zero are inactive
`timescale 1ns/1ns
`default_nettype none
module gpied_top #(
  parameter int unsigned NPINS = gpied_pkg::NPINS
) (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic [NPINS-1:0]     pin_in,
  input  wire gpied_pkg::gpied_req_t req,
  output var gpied_pkg::gpied_rsp_t  rsp,
  output logic      [NPINS-1:0]     pin_enable,
  output logic      [NPINS-1:0]     pin_dir,
  output logic      [NPINS-1:0]     pin_out_data
);
  typedef struct packed {
    logic [NPINS-1:0] en;
    logic [NPINS-1:0] dir;
    logic [NPINS-1:0] out_data;
    logic [NPINS-1:0] rise_en;
    logic [NPINS-1:0] fall_en;
    logic [NPINS-1:0] rise_flags;
    logic [NPINS-1:0] fall_flags;
    logic [NPINS-1:0] prev;
    gpied_pkg::gpied_rsp_t rsp;
  } gpied_state_t;

  gpied_state_t     s;
  gpied_state_t     next_s;
  logic [NPINS-1:0] pin_sync;
  logic [NPINS-1:0] active;
  logic [NPINS-1:0] rise_hit;
  logic [NPINS-1:0] fall_hit;
  logic [NPINS-1:0] level;
  logic             rd_status;
  logic [23:0]      rdata;

  gpied_sync #(
    .WIDTH     (NPINS)
  ) u_sync (
    .clk       (clk),
    .srst      (srst),
    .pin_async (pin_in),
    .pin_sync  (pin_sync)
  );

  // a pin leaving input mode drops out at once; flags it already set stay until read
  assign active    = s.en & ~s.dir;
  assign level     = pin_sync & active;
  assign rise_hit  = active & s.rise_en & pin_sync & ~s.prev;
  assign fall_hit  = active & s.fall_en & ~pin_sync & s.prev;
  assign rd_status = req.rd && (req.addr == gpied_pkg::OFS_INPUT_DATA);

  always_comb
  begin
    rdata = gpied_pkg::RST_WORD;
    unique case (req.addr)
      gpied_pkg::OFS_PORT_CTRL:
      begin
        rdata[gpied_pkg::POS_HI  +: NPINS] = s.en;
        rdata[gpied_pkg::POS_MID +: NPINS] = s.dir;
        rdata[gpied_pkg::POS_LO  +: NPINS] = s.out_data;
      end
      gpied_pkg::OFS_EDGE_ENABLE:
      begin
        rdata[gpied_pkg::POS_HI  +: NPINS] = s.rise_en;
        rdata[gpied_pkg::POS_MID +: NPINS] = s.fall_en;
      end
      gpied_pkg::OFS_INPUT_DATA:
      begin
        // reserved bits stay zero
        rdata[gpied_pkg::POS_HI  +: NPINS] = s.rise_flags;
        rdata[gpied_pkg::POS_MID +: NPINS] = s.fall_flags;
        rdata[gpied_pkg::POS_LO  +: NPINS] = level;
      end
      default:
      begin
        // summary register and unmapped indices read zero here
        rdata = gpied_pkg::RST_WORD;
      end
    endcase
  end

  always_comb
  begin
    next_s           = s;
    // prev follows pin_sync every cycle, so turning an enable on never makes a false edge
    next_s.prev      = pin_sync;
    next_s.rsp.valid = req.rd;
    next_s.rsp.data  = req.rd ? rdata : gpied_pkg::RST_WORD;
    // set wins over read clear so an edge in the read cycle is kept
    if (rd_status)
    begin
      next_s.rise_flags = rise_hit;
      next_s.fall_flags = fall_hit;
    end
    else
    begin
      next_s.rise_flags = s.rise_flags | rise_hit;
      next_s.fall_flags = s.fall_flags | fall_hit;
    end
    if (req.wr)
    begin
      if (req.addr == gpied_pkg::OFS_PORT_CTRL)
      begin
        next_s.en       = req.wdata[gpied_pkg::POS_HI  +: NPINS];
        next_s.dir      = req.wdata[gpied_pkg::POS_MID +: NPINS];
        next_s.out_data = req.wdata[gpied_pkg::POS_LO  +: NPINS];
      end
      if (req.addr == gpied_pkg::OFS_EDGE_ENABLE)
      begin
        next_s.rise_en = req.wdata[gpied_pkg::POS_HI  +: NPINS];
        next_s.fall_en = req.wdata[gpied_pkg::POS_MID +: NPINS];
      end
      // status register writes are ignored
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rsp          = s.rsp;
  assign pin_enable   = s.en;
  assign pin_dir      = s.dir;
  assign pin_out_data = s.out_data;

  // level checks look at pin_in itself, so a broken synchroniser is caught as well
  chk_fall_needs_enable: assert property (@(posedge clk) disable iff (srst)
    1 |=> ((s.fall_flags & ~$past(s.fall_flags) & ~$past(s.fall_en)) == '0))
    else $error("fall flag set without fall enable");

  chk_rise_needs_enable: assert property (@(posedge clk) disable iff (srst)
    1 |=> ((s.rise_flags & ~$past(s.rise_flags) & ~$past(s.rise_en)) == '0))
    else $error("rise flag set without rise enable");

  chk_rise_edge_sets: assert property (@(posedge clk) disable iff (srst)
    (|rise_hit) |=> ((s.rise_flags & $past(rise_hit)) == $past(rise_hit)))
    else $error("rise edge not flagged");

  chk_fall_edge_sets: assert property (@(posedge clk) disable iff (srst)
    (|fall_hit) |=> ((s.fall_flags & $past(fall_hit)) == $past(fall_hit)))
    else $error("fall edge not flagged");

  chk_flags_sticky: assert property (@(posedge clk) disable iff (srst)
    !rd_status |=> ((s.rise_flags & $past(s.rise_flags)) == $past(s.rise_flags)
                 && (s.fall_flags & $past(s.fall_flags)) == $past(s.fall_flags)))
    else $error("flag dropped without status read");

  chk_read_clears: assert property (@(posedge clk) disable iff (srst)
    rd_status |=> (rsp.valid && rsp.data[21:16] == $past(s.rise_flags)
                && rsp.data[13:8] == $past(s.fall_flags)
                && s.rise_flags == $past(rise_hit) && s.fall_flags == $past(fall_hit)))
    else $error("status read did not return and clear flags");

  chk_level_bits: assert property (@(posedge clk) disable iff (srst)
    rd_status |=> (rsp.data[5:0] == ($past(pin_in, 3) & $past(s.en & ~s.dir))))
    else $error("level bits wrong");

  chk_reset_clear: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> (s.rise_flags == '0 && s.fall_flags == '0 && s.rise_en == '0
                     && s.fall_en == '0 && s.en == '0 && s.dir == '0))
    else $error("flags not clear after reset");

  chk_inactive_quiet: assert property (@(posedge clk) disable iff (srst)
    1 |=> (((s.rise_flags | s.fall_flags) & ~($past(s.rise_flags) | $past(s.fall_flags))
            & ~$past(s.en & ~s.dir)) == '0))
    else $error("flag set on inactive or output pin");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (srst)
    rd_status |=> (rsp.data[23:22] == 2'h0 && rsp.data[15:14] == 2'h0 && rsp.data[7:6] == 2'h0))
    else $error("reserved status bits not zero");

  chk_disabled_quiet: assert property (@(posedge clk) disable iff (srst)
    1 |=> (((s.rise_flags | s.fall_flags) & ~($past(s.rise_flags) | $past(s.fall_flags))
            & ~$past(s.en)) == '0))
    else $error("flag set on disabled pin");

  chk_status_write_ignored: assert property (@(posedge clk) disable iff (srst)
    (req.wr && (req.addr == gpied_pkg::OFS_INPUT_DATA || req.addr == gpied_pkg::OFS_INT_SUMMARY))
    |=> ($stable(s.en) && $stable(s.dir) && $stable(s.out_data)
         && $stable(s.rise_en) && $stable(s.fall_en)))
    else $error("write to read-only register changed state");

  chk_port_ctrl_write: assert property (@(posedge clk) disable iff (srst)
    (req.wr && req.addr == gpied_pkg::OFS_PORT_CTRL)
    |=> (pin_enable == $past(req.wdata[gpied_pkg::POS_HI +: NPINS])
         && pin_dir == $past(req.wdata[gpied_pkg::POS_MID +: NPINS])
         && pin_out_data == $past(req.wdata[gpied_pkg::POS_LO +: NPINS])))
    else $error("port control write not applied");

  chk_edge_enable_write: assert property (@(posedge clk) disable iff (srst)
    (req.wr && req.addr == gpied_pkg::OFS_EDGE_ENABLE)
    |=> (s.rise_en == $past(req.wdata[gpied_pkg::POS_HI +: NPINS])
         && s.fall_en == $past(req.wdata[gpied_pkg::POS_MID +: NPINS])))
    else $error("edge enable write not applied");

  cov_rise_flag: cover property (@(posedge clk) disable iff (srst) |rise_hit ##1 rd_status);
  cov_fall_flag: cover property (@(posedge clk) disable iff (srst) |fall_hit ##1 rd_status);
  cov_edge_in_read: cover property (@(posedge clk) disable iff (srst) rd_status && (|rise_hit));
  cov_status_write: cover property (@(posedge clk) disable iff (srst) req.wr && (req.addr == gpied_pkg::OFS_INPUT_DATA));
  cov_output_pin_edge: cover property (@(posedge clk) disable iff (srst) |((pin_sync ^ s.prev) & s.en & s.dir));
endmodule
`default_nettype wire

/* File: bench/gpied_pins.sv */
// Purpose: external digital signals on the gpio input pins
// Assumes: levels set by the bench at the falling clock edge
// Notes:   a small delay keeps pin changes unrelated to the clock edge
`timescale 1ns/1ns
`default_nettype none
module gpied_pins (
  input  wire logic [5:0] level,
  output logic      [5:0] pin_in
);
  always @(level) pin_in <= #7 level;
endmodule
`default_nettype wire

/* File: bench/gpied_bench.sv */
// Purpose: self-checking bench for the gpio input edge detect block
// Assumes: register requests as one-cycle strobes, answer one cycle later
// Notes:   pins are pushed through the external signal model
`timescale 1ns/1ns
`default_nettype none
module gpied_bench;
  logic                  clk;
  logic                  srst;
  logic [5:0]            lvl;
  logic [5:0]            pin_in;
  logic [5:0]            pen;
  logic [5:0]            pdir;
  logic [5:0]            pout;
  logic [23:0]           d;
  gpied_pkg::gpied_req_t req;
  gpied_pkg::gpied_rsp_t rsp;
  int                    n_mismatch;
  int                    checks;

  gpied_pins ext (.level(lvl), .pin_in(pin_in));
  gpied_top dut (.clk(clk), .srst(srst), .pin_in(pin_in), .req(req), .rsp(rsp),
                 .pin_enable(pen), .pin_dir(pdir), .pin_out_data(pout));

  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    @(negedge clk);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(negedge clk);
    req.wr = 1'b0;
  endtask
  // answer stands one cycle only, so it is caught at the first falling edge
  task automatic rd(input logic [7:0] a, output logic [23:0] v);
    int i;
    @(negedge clk);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 24'h000000};
    @(negedge clk);
    req.rd = 1'b0;
    i = 0;
    while (rsp.valid !== 1'b1 && i < 4)
    begin
      @(negedge clk);
      i++;
    end
    if (i == 4)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    v = rsp.data;
  endtask

  task automatic s_reset;
    chk("pin_ctrl", 24'h000000, {2'h0, pen, 2'h0, pdir, 2'h0, pout});
    rd(8'h06, d);
    chk("status", 24'h000000, d);
    rd(8'h05, d);
    chk("edge_en", 24'h000000, d);
  endtask
  task automatic s_level;
    wr(8'h04, 24'h3f0000);
    lvl = 6'h2a;
    idle(4);
    rd(8'h06, d);
    chk("level", 24'h00002a, d);
    wr(8'h04, 24'h3f0f15);
    idle(4);
    chk("pin_ctrl", 24'h3f0f15, {2'h0, pen, 2'h0, pdir, 2'h0, pout});
    rd(8'h04, d);
    chk("port_rd", 24'h3f0f15, d);
    rd(8'h06, d);
    chk("dir_level", 24'h000020, d);
  endtask
  // reserved bits 23:22, 15 and 7:0 written as ones must read back as zero
  task automatic s_edges;
    wr(8'h04, 24'h3f0000);
    wr(8'h05, 24'hcfbcff);
    rd(8'h05, d);
    chk("edge_en", 24'h0f3c00, d);
    lvl = 6'h15;
    idle(4);
    lvl = 6'h2a;
    idle(4);
    rd(8'h06, d);
    chk("flags", 24'h0f3c2a, d);
    rd(8'h06, d);
    chk("cleared", 24'h00002a, d);
  endtask
  // edge lands on the read edge itself: old value returned, new flag kept
  task automatic s_race;
    lvl = 6'h2b;
    @(negedge clk);
    rd(8'h06, d);
    chk("race_old", 24'h000000, d & 24'hffff00);
    rd(8'h06, d);
    chk("race_kept", 24'h01002b, d);
  endtask
  task automatic s_reserved;
    wr(8'h06, 24'hffffff);
    wr(8'h07, 24'hffffff);
    rd(8'h06, d);
    chk("ro_status", 24'h00002b, d);
    rd(8'h07, d);
    chk("summary", 24'h000000, d);
    rd(8'h3c, d);
    chk("unmapped", 24'h000000, d);
  endtask
  // pins 1,3,4 active inputs; pin 2 is an output and pin 5 disabled, both with edges enabled
  task automatic s_inactive;
    wr(8'h04, 24'h1e0415);
    rd(8'h04, d);
    chk("port_rd", 24'h1e0415, d);
    chk("pin_ctrl", 24'h1e0415, {2'h0, pen, 2'h0, pdir, 2'h0, pout});
    lvl = 6'h14;
    idle(4);
    rd(8'h06, d);
    chk("inactive", 24'h000810, d);
  endtask
  // a reset in mid-run must drop a pending flag and every setting
  task automatic s_midreset;
    lvl = 6'h1c;
    idle(4);
    srst = 1'b1;
    idle(2);
    srst = 1'b0;
    chk("rst_ctrl", 24'h000000, {2'h0, pen, 2'h0, pdir, 2'h0, pout});
    rd(8'h06, d);
    chk("rst_status", 24'h000000, d);
    rd(8'h05, d);
    chk("rst_edge_en", 24'h000000, d);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    srst = 1'b1;
    lvl = 6'h3f;
    req = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    s_reset();
    s_level();
    s_edges();
    s_race();
    s_reserved();
    s_inactive();
    s_midreset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
